/* src/scp_defines.vh */
// constants for the serial command port: commands, selectors, fields, resets
`ifndef SCP_DEFINES_VH
`define SCP_DEFINES_VH

// frame layout
`define SCP_FRAME_W        24
`define SCP_ADDR_MSB       23
`define SCP_ADDR_LSB       16
`define SCP_DATA_MSB       15
`define SCP_DATA_LSB       0

// command address bytes
`define SCP_CMD_NOP        8'h00
`define SCP_CMD_CODE       8'h01
`define SCP_CMD_READ       8'h02
`define SCP_CMD_CONTROL    8'h55
`define SCP_CMD_RESET      8'h56
`define SCP_CMD_CONFIG     8'h57
`define SCP_CMD_GAIN       8'h58
`define SCP_CMD_OFFSET     8'h59
`define SCP_CMD_WDOG       8'h95
`define SCP_CMD_CKSUM_CLR  8'h96

// read selector, data bits 5:0
`define SCP_SEL_MSB        5
`define SCP_SEL_STATUS     2'h0
`define SCP_SEL_CODE       2'h1
`define SCP_SEL_CONTROL    2'h2
`define SCP_SEL_CONFIG     6'h0b
`define SCP_SEL_GAIN       6'h13
`define SCP_SEL_OFFSET     6'h17

// control word fields
`define SCP_CTL_CLEAR_VALUE_SELECT     15
`define SCP_CTL_RSVD       3
`define SCP_CTL_RANGE_MSB  2
`define SCP_RANGE_BAD      3'h4
// configuration word: reserved bits read as zero
`define SCP_CFG_KEEP       16'h07bf
// soft reset command bit
`define SCP_RST_BIT        0
// low data bits dropped on the 12-bit variant
`define SCP_LOW_MASK       16'hfff0

// status word bit positions
`define SCP_ST_OVERTEMP    0
`define SCP_ST_SLEW        1
`define SCP_ST_LOOP        2
`define SCP_ST_WDOG        3
`define SCP_ST_CKSUM       4

// reset values
`define SCP_RST_FRAME      24'h000000
`define SCP_RST_CODE       16'h0000
`define SCP_RST_CONTROL    16'h0000
`define SCP_RST_CONFIG     16'h0000
`define SCP_RST_GAIN       16'h0000
`define SCP_RST_OFFSET     16'h0000

// clear codes after a range change
`define SCP_CODE_ZERO      16'h0000
`define SCP_CODE_MID       16'h8000

// timing: fastest serial clock and the system clock, in kHz
`define SCP_SCLK_MAX_KHZ   30000
`define SCP_SYS_CLK_KHZ    250000
// fewest system cycles in one serial clock period (rounded down)
`define SCP_SCLK_MIN_CYC   (`SCP_SYS_CLK_KHZ / `SCP_SCLK_MAX_KHZ)

`endif

/* src/scp_sync.v */
// two-flop synchroniser for a group of independent asynchronous levels
`default_nettype none

module scp_sync #(
    parameter W = 8
) (
    // clock and reset
    input  wire         i_clk,
    input  wire         i_rst_n,
    // asynchronous levels in, synchronised levels out
    input  wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);

    reg [W-1:0] meta_q;   // first stage, read only by the second
    reg [W-1:0] sync_q;   // second stage

    // each bit is independent; no multi-bit word crosses here
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;

endmodule

`default_nettype wire

/* src/scp_shift.v */
// 24-bit input shift register of the serial command port
`include "scp_defines.vh"
`default_nettype none

module scp_shift (
    // clock and reset
    input  wire                     i_clk,
    input  wire                     i_rst_n,
    // soft reset clears the frame as well
    input  wire                     i_clr,
    // one-cycle strobe per rising serial clock edge, with its bit
    input  wire                     i_shift,
    input  wire                     i_bit,
    // frame contents, msb received first
    output wire [`SCP_FRAME_W-1:0]  o_frame
);

    reg [`SCP_FRAME_W-1:0] frame_q;

    // shift on every serial clock rise, latch level does not matter
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            frame_q <= `SCP_RST_FRAME;
        end else if (i_clr) begin
            frame_q <= `SCP_RST_FRAME;
        end else if (i_shift) begin
            frame_q <= {frame_q[`SCP_FRAME_W-2:0], i_bit};
        end
    end

    assign o_frame = frame_q;

endmodule

`default_nettype wire

/* src/scp_top.v */
// serial command port: frame capture, command decode, registers, readback
`include "scp_defines.vh"
`default_nettype none

module scp_top #(
    // 1 selects the 12-bit variant, 0 the 16-bit one
    parameter TWELVE_BIT = 0
) (
    // clock and reset
    input  wire        i_sys_clk,
    input  wire        i_rst_n,
    // serial pins from the host, asynchronous
    input  wire        i_sclk,
    input  wire        i_latch,
    input  wire        i_serial_in_pin,
    // serial readback pin
    output wire        o_serial_out_pin,
    // fault and state levels from the analog side, asynchronous
    input  wire        i_checksum_err,
    input  wire        i_watchdog_fault,
    input  wire        i_loop_fault,
    input  wire        i_slew_active,
    input  wire        i_overtemp,
    // register contents toward the converter core
    output wire [15:0] o_output_code,
    output wire [15:0] o_control_word,
    output wire [15:0] o_configuration_word,
    output wire [15:0] o_gain_trim,
    output wire [15:0] o_offset_trim,
    // one-cycle command pulses
    output wire        o_soft_reset,
    output wire        o_watchdog_restart,
    output wire        o_code_written
);

    // synchronised pin and status levels
    wire [7:0] sync_w;
    wire       s_sclk     = sync_w[0];
    wire       s_latch    = sync_w[1];
    wire       s_sdi      = sync_w[2];
    wire       s_cksum    = sync_w[3];
    wire       s_wdog     = sync_w[4];
    wire       s_loop     = sync_w[5];
    wire       s_slew     = sync_w[6];
    wire       s_otemp    = sync_w[7];

    reg        sclk_prev_q;      // last synchronised serial clock
    reg        latch_prev_q;     // last synchronised latch level
    wire       sclk_rise;
    wire       sclk_fall;
    wire       latch_rise;

    wire [`SCP_FRAME_W-1:0] frame_w;
    wire [7:0]  addr_w;          // command address byte
    wire [15:0] data_w;          // data word

    // stored registers
    reg [15:0] code_q;
    reg [15:0] ctl_q;
    reg [15:0] cfg_q;
    reg [15:0] gain_q;
    reg [15:0] ofs_q;
    reg        cksum_flag_q;     // sticky checksum fault
    reg        soft_rst_q;       // soft reset pulse
    reg        wdog_rst_q;       // watchdog restart pulse
    reg        code_wr_q;        // output code changed pulse

    // readback path
    reg [15:0] rd_q;             // outgoing word
    reg        sdo_q;            // pin flop
    reg [15:0] rd_sel;           // word picked by the selector
    wire [15:0] status_w;

    // write-side helpers
    reg [15:0] ctl_new;          // control word as it would be stored
    reg [15:0] clr_code;         // code after a range change
    wire [15:0] low_mask;        // drops low bits on the 12-bit part

    // three pins and five status levels, all from other domains
    scp_sync #(
        .W       (8)
    ) u_sync (
        .i_clk   (i_sys_clk),
        .i_rst_n (i_rst_n),
        .i_async ({i_overtemp, i_slew_active, i_loop_fault,
                   i_watchdog_fault, i_checksum_err,
                   i_serial_in_pin, i_latch, i_sclk}),
        .o_sync  (sync_w)
    );

    // edge finding on the synchronised clock and latch
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_prev_q  <= 1'b0;
            latch_prev_q <= 1'b0;
        end else begin
            sclk_prev_q  <= s_sclk;
            latch_prev_q <= s_latch;
        end
    end

    // data goes through the same two flops as the clock, so it
    // stays aligned with the rise that samples it
    // at the fastest serial clock each half period still spans
    // at least four samples, so no edge is missed
    assign sclk_rise  = s_sclk & ~sclk_prev_q;
    assign sclk_fall  = ~s_sclk & sclk_prev_q;
    assign latch_rise = s_latch & ~latch_prev_q;

    // input shift register, not qualified by the latch level
    scp_shift u_shift (
        .i_clk   (i_sys_clk),
        .i_rst_n (i_rst_n),
        .i_clr   (soft_rst_q),
        .i_shift (sclk_rise),
        .i_bit   (s_sdi),
        .o_frame (frame_w)
    );

    // split the frame into address byte and data word
    assign addr_w = frame_w[`SCP_ADDR_MSB:`SCP_ADDR_LSB];
    assign data_w = frame_w[`SCP_DATA_MSB:`SCP_DATA_LSB];

    // 12-bit variant ignores the four lowest data bits of code, gain and offset
    assign low_mask = (TWELVE_BIT != 0) ? `SCP_LOW_MASK
                                        : 16'hffff;

    // status word: five flags in the low bits, rest reserved zero
    assign status_w = {11'h000,
                       cksum_flag_q,
                       s_wdog,
                       s_loop,
                       s_slew,
                       s_otemp};

    // control word candidate: reserved bit forced low,
    // forbidden range keeps the old one
    always @* begin
        ctl_new = data_w;
        ctl_new[`SCP_CTL_RSVD] = 1'b0;
        if (data_w[`SCP_CTL_RANGE_MSB:0] == `SCP_RANGE_BAD) begin
            ctl_new[`SCP_CTL_RANGE_MSB:0] =
                ctl_q[`SCP_CTL_RANGE_MSB:0];
        end
    end

    // clear code from the new range and the clear select bit:
    // voltage ranges give 0 V or midscale/negative full scale,
    // current ranges give the low end of the range
    always @* begin
        clr_code = `SCP_CODE_ZERO;
        case (ctl_new[`SCP_CTL_RANGE_MSB:0])
            3'h0, 3'h1: begin // unipolar voltage
                clr_code = ctl_new[`SCP_CTL_CLEAR_VALUE_SELECT] ? `SCP_CODE_MID
                                                   : `SCP_CODE_ZERO;
            end
            3'h2, 3'h3: begin // bipolar voltage
                clr_code = ctl_new[`SCP_CTL_CLEAR_VALUE_SELECT] ? `SCP_CODE_ZERO
                                                   : `SCP_CODE_MID;
            end
            default: begin // current ranges
                clr_code = `SCP_CODE_ZERO;
            end
        endcase
    end

    // readback selector: low two bits decide unless both set,
    // then the full six bits must match
    always @* begin
        rd_sel = 16'h0000;
        case (data_w[1:0])
            `SCP_SEL_STATUS:  rd_sel = status_w;
            `SCP_SEL_CODE:    rd_sel = code_q;
            `SCP_SEL_CONTROL: rd_sel = ctl_q;
            default: begin
                case (data_w[`SCP_SEL_MSB:0])
                    `SCP_SEL_CONFIG: rd_sel = cfg_q;
                    `SCP_SEL_GAIN:   rd_sel = gain_q;
                    `SCP_SEL_OFFSET: rd_sel = ofs_q;
                    default:         rd_sel = 16'h0000;
                endcase
            end
        endcase
    end

    // command decode, committed on every latch rise
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            code_q     <= `SCP_RST_CODE;
            ctl_q      <= `SCP_RST_CONTROL;
            cfg_q      <= `SCP_RST_CONFIG;
            gain_q     <= `SCP_RST_GAIN;
            ofs_q      <= `SCP_RST_OFFSET;
            soft_rst_q <= 1'b0;
            wdog_rst_q <= 1'b0;
            code_wr_q  <= 1'b0;
        end else begin
            // pulses last a single cycle
            soft_rst_q <= 1'b0;
            wdog_rst_q <= 1'b0;
            code_wr_q  <= 1'b0;
            if (soft_rst_q) begin
                // soft reset returns code, control, config, gain and offset to default
                code_q <= `SCP_RST_CODE;
                ctl_q  <= `SCP_RST_CONTROL;
                cfg_q  <= `SCP_RST_CONFIG;
                gain_q <= `SCP_RST_GAIN;
                ofs_q  <= `SCP_RST_OFFSET;
            end else if (latch_rise) begin
                case (addr_w)
                    `SCP_CMD_CODE: begin
                        code_q    <= data_w & low_mask;
                        code_wr_q <= 1'b1;
                    end
                    `SCP_CMD_CONTROL: begin
                        ctl_q <= ctl_new;
                        // a changed range clears the output code
                        if (ctl_new[`SCP_CTL_RANGE_MSB:0] !=
                            ctl_q[`SCP_CTL_RANGE_MSB:0]) begin
                            code_q    <= clr_code;
                            code_wr_q <= 1'b1;
                        end
                    end
                    `SCP_CMD_RESET: begin
                        soft_rst_q <= data_w[`SCP_RST_BIT];
                    end
                    `SCP_CMD_CONFIG: begin
                        cfg_q <= data_w & `SCP_CFG_KEEP;
                    end
                    `SCP_CMD_GAIN: begin
                        gain_q <= data_w & low_mask;
                    end
                    `SCP_CMD_OFFSET: begin
                        ofs_q <= data_w & low_mask;
                    end
                    `SCP_CMD_WDOG: begin
                        // restart only, data word ignored
                        wdog_rst_q <= 1'b1;
                    end
                    `SCP_CMD_NOP, `SCP_CMD_READ, `SCP_CMD_CKSUM_CLR: begin
                        // none of the five data registers stored; read and checksum clear act in their own blocks
                    end
                    default: begin
                        // unknown address: leave all alone
                    end
                endcase
            end
        end
    end

    // sticky checksum fault: a new error in the clearing cycle
    // wins, so an event is never lost
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cksum_flag_q <= 1'b0;
        end else if (s_cksum) begin
            cksum_flag_q <= 1'b1;
        end else if (latch_rise && addr_w == `SCP_CMD_CKSUM_CLR) begin
            cksum_flag_q <= 1'b0;
        end
    end

    // readback shifter: loaded on the latch rise, shifted on each
    // serial clock fall; a non-read frame loads zeros so stale data
    // never leaks into the next frame
    always @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_q  <= 16'h0000;
            sdo_q <= 1'b0;
        end else if (soft_rst_q) begin
            rd_q  <= 16'h0000;
            sdo_q <= 1'b0;
        end else if (latch_rise) begin
            if (addr_w == `SCP_CMD_READ) begin
                rd_q  <= rd_sel;
                sdo_q <= rd_sel[15];
            end else begin
                rd_q  <= 16'h0000;
                sdo_q <= 1'b0;
            end
        end else if (sclk_fall) begin
            // falling edge presents the next lower bit
            rd_q  <= {rd_q[14:0], 1'b0};
            sdo_q <= rd_q[14];
        end
    end

    // outputs, each straight from a flop
    assign o_serial_out_pin     = sdo_q;
    assign o_output_code        = code_q;
    assign o_control_word       = ctl_q;
    assign o_configuration_word = cfg_q;
    assign o_gain_trim          = gain_q;
    assign o_offset_trim        = ofs_q;
    assign o_soft_reset         = soft_rst_q;
    assign o_watchdog_restart   = wdog_rst_q;
    assign o_code_written       = code_wr_q;

endmodule

`default_nettype wire

/* verification/scp_chk.sv */
// port assertions of the serial command port
`default_nettype none
module scp_chk #(
    parameter TWELVE_BIT = 0
) (
    // clock, reset, serial pins
    input wire logic        i_sys_clk,
    input wire logic        i_rst_n,
    input wire logic        i_sclk,
    input wire logic        i_latch,
    // outputs under watch
    input wire logic        o_serial_out_pin,
    input wire logic [15:0] o_output_code,
    input wire logic [15:0] o_control_word,
    input wire logic [15:0] o_configuration_word,
    input wire logic [15:0] o_gain_trim,
    input wire logic [15:0] o_offset_trim,
    input wire logic        o_soft_reset,
    input wire logic        o_watchdog_restart,
    input wire logic        o_code_written
);
    timeunit 1ns;
    timeprecision 100ps;
    logic        lat_q;     // latch pin, last sample
    logic        sck_q;     // serial clock, last sample
    logic [3:0]  lat_age_q; // cycles since latch rise
    logic [3:0]  fal_age_q; // cycles since clock fall
    logic [79:0] regs;      // all stored registers
    logic        lat_win;   // answer window after latch
    logic        fal_win;   // answer window after fall
    assign regs = {o_output_code, o_control_word, o_configuration_word,
                   o_gain_trim, o_offset_trim};
    // wide windows: the synchroniser adds a cycle of phase doubt
    assign lat_win = (lat_age_q >= 4'h2) && (lat_age_q <= 4'h7);
    assign fal_win = (fal_age_q >= 4'h2) && (fal_age_q <= 4'h7);
    // edge ages saturate so an old edge never reopens a window
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lat_q     <= 1'b0;
            sck_q     <= 1'b0;
            lat_age_q <= 4'hf;
            fal_age_q <= 4'hf;
        end else begin
            lat_q     <= i_latch;
            sck_q     <= i_sclk;
            lat_age_q <= (i_latch && !lat_q) ? 4'h1 :
                         lat_age_q + {3'h0, lat_age_q != 4'hf};
            fal_age_q <= (!i_sclk && sck_q) ? 4'h1 :
                         fal_age_q + {3'h0, fal_age_q != 4'hf};
        end
    end
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    property p_srst_pulse;
        o_soft_reset |=> !o_soft_reset;
    endproperty
    a_srst_pulse: assert property (p_srst_pulse)
        else $error("soft reset pulse too long");
    property p_srst_clear;
        o_soft_reset |-> ##[1:2] (regs == 80'h0);
    endproperty
    a_srst_clear: assert property (p_srst_clear)
        else $error("soft reset left registers set");
    property p_wd_pulse;
        o_watchdog_restart |=> !o_watchdog_restart;
    endproperty
    a_wd_pulse: assert property (p_wd_pulse)
        else $error("watchdog restart pulse too long");
    property p_cmd_latch;
        (o_soft_reset || o_watchdog_restart || o_code_written) |-> lat_win;
    endproperty
    a_cmd_latch: assert property (p_cmd_latch)
        else $error("command pulse without latch rise");
    property p_regs_latch;
        !$stable(regs) |-> lat_win;
    endproperty
    a_regs_latch: assert property (p_regs_latch)
        else $error("register changed without latch rise");
    property p_code_flag;
        $changed(o_output_code) && !$past(o_soft_reset) &&
        !$past(o_soft_reset, 2) |-> o_code_written;
    endproperty
    a_code_flag: assert property (p_code_flag)
        else $error("code changed without its pulse");
    property p_rsvd;
        o_control_word[3] == 1'b0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("control reserved bit set");
    property p_range;
        o_control_word[2:0] != 3'h4;
    endproperty
    a_range: assert property (p_range)
        else $error("forbidden range stored");
    property p_low4;
        (TWELVE_BIT != 0) |-> ({o_output_code[3:0], o_gain_trim[3:0],
                                o_offset_trim[3:0]} == 12'h000);
    endproperty
    a_low4: assert property (p_low4)
        else $error("low nibble set on 12-bit variant");
    property p_sdo;
        !$stable(o_serial_out_pin) |-> (lat_win || fal_win);
    endproperty
    a_sdo: assert property (p_sdo)
        else $error("readback changed off a clock fall");
endmodule
bind scp_top scp_chk #(.TWELVE_BIT(TWELVE_BIT)) scp_chk_inst (.*);
`default_nettype wire

/* verification/scp_host.sv */
// host controller model driving frames onto the serial pins
`default_nettype none
module scp_host (
    // pins toward the port
    output var logic  o_sclk,
    output var logic  o_latch,
    output var logic  o_sdi,
    // readback pin
    input  wire logic i_sdo
);
    timeunit 1ns;
    timeprecision 100ps;
    // clock parked low between frames; one device, so no gating
    initial begin
        o_sclk = 1'b0;
        o_latch = 1'b0;
        o_sdi = 1'b1;
    end
    // one frame, msb first; rd holds the 16 bits read back meanwhile
    task automatic frame(input logic [23:0] f, output logic [15:0] rd);
        int k;
        #1.3;
        for (k = 23; k >= 0; k--) begin
            o_sdi = f[k];
            #16 o_sclk = 1'b1;
            #16;
            // sample just before the fall: previous bit long settled
            if (k > 7) rd[k-8] = i_sdo;
            o_sclk = 1'b0;
        end
        o_sdi = ~f[0]; // released line shows no stale level
        #16 o_latch = 1'b1;
        #32 o_latch = 1'b0;
        #32;
    endtask
endmodule
`default_nettype wire

/* verification/scp_top_tb_top.sv */
// self-checking bench of the serial command port
`default_nettype none
module scp_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TW = 1;          // 12-bit variant, low nibbles drop
    logic        clk = 1'b0;        // system clock
    logic        rst_n = 1'b0;      // async reset
    logic [4:0]  flt = 5'h00;       // cksum, wdog, loop, slew, temp
    logic        sclk, latch, serial_in_pin, serial_out_pin;
    logic [15:0] code, ctl, cfg, gain, ofs;
    logic        wdr;               // watchdog restart pulse
    logic        srs;               // soft reset pulse
    logic        cwr;               // code written pulse
    int          sr_cnt = 0;        // soft reset pulses seen
    int          cw_cnt = 0;        // code written pulses seen
    int          miscompares = 0;
    int          n_tests = 0;
    int          wd_cnt = 0;        // restart pulses seen
    int          i;
    logic [7:0]  wa[5] = '{8'h55, 8'h01, 8'h57, 8'h58, 8'h59};
    logic [15:0] wd[5] = '{16'h7ae9, 16'h1234, 16'hffff, 16'habcd, 16'h5a5a};
    logic [15:0] we[5] = '{16'h7ae1, 16'h1230, 16'h07bf, 16'habc0, 16'h5a50};
    logic [5:0]  ws[6] = '{6'h1e, 6'h2d, 6'h0b, 6'h13, 6'h17, 6'h3c};
    scp_top #(.TWELVE_BIT(TW)) scp_top_inst (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_latch(latch),
        .i_serial_in_pin(serial_in_pin), .o_serial_out_pin(serial_out_pin),
        .i_checksum_err(flt[4]), .i_watchdog_fault(flt[3]),
        .i_loop_fault(flt[2]), .i_slew_active(flt[1]), .i_overtemp(flt[0]),
        .o_output_code(code), .o_control_word(ctl),
        .o_configuration_word(cfg), .o_gain_trim(gain),
        .o_offset_trim(ofs), .o_soft_reset(srs),
        .o_watchdog_restart(wdr), .o_code_written(cwr)
    );
    scp_host scp_host_inst (
        .o_sclk(sclk), .o_latch(latch), .o_sdi(serial_in_pin), .i_sdo(serial_out_pin)
    );
    // 250 MHz system clock
    initial begin
        forever #2 clk = ~clk;
    end
    // count restart, soft reset and code written pulses
    always @(posedge clk) begin
        if (wdr === 1'b1) wd_cnt++;
        if (srs === 1'b1) sr_cnt++;
        if (cwr === 1'b1) cw_cnt++;
    end
    // compare and report
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one command frame, then settle for two clock edges
    task wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] rd;
        scp_host_inst.frame({a, d}, rd);
        repeat (2) @(posedge clk);
    endtask
    // read request with junk high bits, then a nop to clock it out
    task rdb(input logic [5:0] s, input logic [15:0] exp);
        logic [15:0] rd;
        scp_host_inst.frame({8'h02, 10'h3ff, s}, rd);
        scp_host_inst.frame(24'h000000, rd);
        chk(rd, exp);
        @(posedge clk);
    endtask
    task regs_are(input logic [15:0] c, k, f, g, o);
        chk(code, c);
        chk(ctl, k);
        chk(cfg, f);
        chk(gain, g);
        chk(ofs, o);
    endtask
    task complete_run;
        if (miscompares == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // hang guard, well beyond the run length
    initial begin
        #100000;
        miscompares++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (i = 0; i < 6; i++) rdb(ws[i], 16'h0000);
        for (i = 0; i < 5; i++) wr(wa[i], wd[i]);
        regs_are(16'h1230, 16'h7ae1, 16'h07bf, 16'habc0, 16'h5a50);
        for (i = 0; i < 5; i++) rdb(ws[i], we[i]);
        // unknown address and storeless commands
        wr(8'h33, 16'hffff);
        wr(8'h95, 16'hffff);
        wr(8'h00, 16'hffff);
        regs_are(16'h1230, 16'h7ae1, 16'h07bf, 16'habc0, 16'h5a50);
        chk(16'(wd_cnt), 16'h0001);
        // forbidden range kept out, range changes clear the code
        wr(8'h55, 16'h8004);
        chk(ctl, 16'h8001);
        chk(code, 16'h1230);
        wr(8'h55, 16'h0002);
        chk(code, 16'h8000);
        wr(8'h55, 16'h8006);
        chk(code, 16'h0000);
        wr(8'h01, 16'h4321);
        wr(8'h55, 16'h8000);
        chk(code, 16'h8000);
        chk(16'(cw_cnt), 16'h0006);
        // sticky checksum flag and live fault levels
        flt <= 5'h1b;
        repeat (4) @(posedge clk);
        flt <= 5'h0b;
        rdb(6'h3c, 16'h001b);
        wr(8'h96, 16'h0000);
        rdb(6'h3c, 16'h000b);
        flt <= 5'h00;
        wr(8'h56, 16'h0001);
        regs_are(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        chk(16'(sr_cnt), 16'h0001);
        // hard reset in mid-run
        wr(8'h01, 16'hfff7);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        regs_are(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
        rdb(6'h2d, 16'h0000);
        complete_run();
    end
endmodule
`default_nettype wire
